// ---- verilog/afi_pkg.sv ----
// Purpose: shared constants for the two-bank interrupt controller
// Assumes: word-aligned register access, paddr carries byte address bits 8:2
// Notes:   normal bank width may be raised up to 32 by editing NORMAL_BANK_WIDTH

package afi_pkg;

    // ==========================================================
    // bank widths
    localparam int NORMAL_BANK_WIDTH = 8;
    localparam int FAST_BANK_WIDTH = 1;
    localparam int DATA_WIDTH = NORMAL_BANK_WIDTH;
    localparam int ADDR_WIDTH = 7;

    // ==========================================================
    // byte offsets from the block base
    localparam logic [8:0] OFF_NORMAL_MASKED = 9'h000;
    localparam logic [8:0] OFF_NORMAL_RAW = 9'h004;
    localparam logic [8:0] OFF_NORMAL_MASK_SET = 9'h008;
    localparam logic [8:0] OFF_NORMAL_MASK_CLR = 9'h00c;
    localparam logic [8:0] OFF_SOFT_TRIGGER = 9'h010;
    localparam logic [8:0] OFF_NORMAL_PATTERN = 9'h014;
    localparam logic [8:0] OFF_NORMAL_SELECT = 9'h018;
    localparam logic [8:0] OFF_FAST_MASKED = 9'h100;
    localparam logic [8:0] OFF_FAST_RAW = 9'h104;
    localparam logic [8:0] OFF_FAST_MASK_SET = 9'h108;
    localparam logic [8:0] OFF_FAST_MASK_CLR = 9'h10c;
    localparam logic [8:0] OFF_FAST_PATTERN = 9'h114;
    localparam logic [8:0] OFF_FAST_SELECT = 9'h118;

    // ==========================================================
    // field positions
    localparam int SOFT_BIT = 1;
    localparam int SELECT_BIT = 0;
    localparam int SHARED_BIT = 0;

    // ==========================================================
    // values after reset
    localparam logic [DATA_WIDTH-1:0] WORD_RESET = 8'h00;
    localparam logic SOFT_RESET = 1'h0;
    localparam logic REQ_N_RESET = 1'h1;

endpackage : afi_pkg

// ---- verilog/afi_sync.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous levels
// Notes:   a change passes once stages two and three agree
`timescale 1ns/1ps

module afi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] held;
    } afi_sync_state_t;

    afi_sync_state_t st;
    afi_sync_state_t next_st;

    // ==========================================================
    // per-bit agreement filter; stage one feeds only stage two
    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.held[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.held;

endmodule : afi_sync

// ---- verilog/afi_bank.sv ----
// Purpose: one interrupt bank: mask, test pattern, source select, status
// Assumes: write strobes are single-cycle and already decoded
// Notes:   status is combinational from synchronised sources
`timescale 1ns/1ps

module afi_bank
    import afi_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] sourcesIn,
    input wire logic [W-1:0] wdata,
    input wire logic wrMaskSet,
    input wire logic wrMaskClr,
    input wire logic wrPattern,
    input wire logic wrSelect,
    output logic [W-1:0] mask,
    output logic [W-1:0] pattern,
    output logic testSelect,
    output logic [W-1:0] unmasked_status,
    output logic [W-1:0] maskedStatus
);

    typedef struct packed {
        logic [W-1:0] mask;
        logic [W-1:0] pattern;
        logic testSelect;
    } afi_bank_state_t;

    afi_bank_state_t st;
    afi_bank_state_t next_st;

    always_comb begin
        next_st = st;
        if (wrMaskSet) begin
            next_st.mask = st.mask | wdata;
        end else if (wrMaskClr) begin
            next_st.mask = st.mask & ~wdata;
        end
        if (wrPattern) begin
            next_st.pattern = wdata;
        end
        if (wrSelect) begin
            next_st.testSelect = wdata[SELECT_BIT];
        end
    end

    // mask only moves through the set and clear strobes
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign mask = st.mask;
    assign pattern = st.pattern;
    assign testSelect = st.testSelect;
    assign unmasked_status = st.testSelect ? st.pattern : sourcesIn;
    assign maskedStatus = unmasked_status & st.mask;

endmodule : afi_bank

// ---- verilog/afi_ctrl.sv ----
// Purpose: peripheral-bus interrupt controller with normal and fast banks
// Assumes: bus master keeps paddr/pwrite stable through setup and enable
// Notes:   request outputs and read data are registered, one cycle behind
`timescale 1ns/1ps

module afi_ctrl
    import afi_pkg::*;
(
    input wire logic clk,
    input wire logic rstN,
    input wire logic blockSelect,
    input wire logic penable,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic pwrite,
    input wire logic [DATA_WIDTH-1:0] pwdata,
    output logic [DATA_WIDTH-1:0] prdata,
    input wire logic fastSourceIn,
    input wire logic [NORMAL_BANK_WIDTH-1:0] normalSourcesIn,
    output logic normalReqOutN,
    output logic fastReqOutN
);

    // ==========================================================
    // state
    typedef struct packed {
        logic softReq;
        logic [DATA_WIDTH-1:0] readWordReg;
        logic normalReqN;
        logic fastReqN;
    } afi_ctrl_state_t;

    afi_ctrl_state_t st;
    afi_ctrl_state_t next_st;

    logic [DATA_WIDTH-1:0] read_word_next;
    logic writeAccess;
    logic readSetup;

    logic wrNormSet;
    logic wrNormClr;
    logic wrSoft;
    logic wrNormPattern;
    logic wrNormSelect;
    logic wrFastSet;
    logic wrFastClr;
    logic wrFastPattern;
    logic wrFastSelect;

    logic [NORMAL_BANK_WIDTH-1:0] normSync;
    logic fastSync;
    logic [NORMAL_BANK_WIDTH-1:0] normSources;

    logic [NORMAL_BANK_WIDTH-1:0] normMask;
    logic [NORMAL_BANK_WIDTH-1:0] normPattern;
    logic normSelect;
    logic [NORMAL_BANK_WIDTH-1:0] normRaw;
    logic [NORMAL_BANK_WIDTH-1:0] normMasked;

    logic [FAST_BANK_WIDTH-1:0] fastMask;
    logic [FAST_BANK_WIDTH-1:0] fastPattern;
    logic fastSelect;
    logic [FAST_BANK_WIDTH-1:0] fastRaw;
    logic [FAST_BANK_WIDTH-1:0] fastMasked;

    // ==========================================================
    // source inputs
    // levels pass through the synchroniser; no edge capture is done here
    afi_sync #(
        .W(NORMAL_BANK_WIDTH + 1)
    ) u_srcSync (
        .clk(clk),
        .rstN(rstN),
        .din({fastSourceIn, normalSourcesIn}),
        .dout({fastSync, normSync})
    );

    // bit 1 is the soft source; bit 0 stays an ordinary input so the
    // fast source can be wired there as well
    always_comb begin
        normSources = normSync;
        normSources[SOFT_BIT] = st.softReq;
    end

    // ==========================================================
    // write decode
    assign writeAccess = blockSelect & penable & pwrite;
    assign readSetup = blockSelect & ~penable & ~pwrite;

    // read-only offsets decode to no strobe at all
    assign wrNormSet = writeAccess && (paddr == OFF_NORMAL_MASK_SET[8:2]);
    assign wrNormClr = writeAccess && (paddr == OFF_NORMAL_MASK_CLR[8:2]);
    assign wrSoft = writeAccess && (paddr == OFF_SOFT_TRIGGER[8:2]);
    assign wrNormPattern = writeAccess && (paddr == OFF_NORMAL_PATTERN[8:2]);
    assign wrNormSelect = writeAccess && (paddr == OFF_NORMAL_SELECT[8:2]);
    assign wrFastSet = writeAccess && (paddr == OFF_FAST_MASK_SET[8:2]);
    assign wrFastClr = writeAccess && (paddr == OFF_FAST_MASK_CLR[8:2]);
    assign wrFastPattern = writeAccess && (paddr == OFF_FAST_PATTERN[8:2]);
    assign wrFastSelect = writeAccess && (paddr == OFF_FAST_SELECT[8:2]);

    // ==========================================================
    // banks
    afi_bank #(
        .W(NORMAL_BANK_WIDTH)
    ) u_normalBank (
        .clk(clk),
        .rstN(rstN),
        .sourcesIn(normSources),
        .wdata(pwdata),
        .wrMaskSet(wrNormSet),
        .wrMaskClr(wrNormClr),
        .wrPattern(wrNormPattern),
        .wrSelect(wrNormSelect),
        .mask(normMask),
        .pattern(normPattern),
        .testSelect(normSelect),
        .unmasked_status(normRaw),
        .maskedStatus(normMasked)
    );

    // single slice at bit 0, no soft source
    afi_bank #(
        .W(FAST_BANK_WIDTH)
    ) u_fastBank (
        .clk(clk),
        .rstN(rstN),
        .sourcesIn(fastSync),
        .wdata(pwdata[0 +: FAST_BANK_WIDTH]),
        .wrMaskSet(wrFastSet),
        .wrMaskClr(wrFastClr),
        .wrPattern(wrFastPattern),
        .wrSelect(wrFastSelect),
        .mask(fastMask),
        .pattern(fastPattern),
        .testSelect(fastSelect),
        .unmasked_status(fastRaw),
        .maskedStatus(fastMasked)
    );

    // ==========================================================
    // read decode
    // software finds the source itself; no priority or vector here
    always_comb begin
        read_word_next = WORD_RESET;
        if (readSetup) begin
            case ({paddr, 2'h0})
                OFF_NORMAL_MASKED: read_word_next = normMasked;
                OFF_NORMAL_RAW: read_word_next = normRaw;
                OFF_NORMAL_MASK_SET: read_word_next = normMask;
                OFF_NORMAL_PATTERN: read_word_next = normPattern;
                OFF_NORMAL_SELECT: read_word_next = {7'h00, normSelect};
                OFF_FAST_MASKED: read_word_next = {7'h00, fastMasked};
                OFF_FAST_RAW: read_word_next = {7'h00, fastRaw};
                // upper mask bits are unimplemented; zero is one legal undefined
                OFF_FAST_MASK_SET: read_word_next = {7'h00, fastMask};
                OFF_FAST_PATTERN: read_word_next = {7'h00, fastPattern};
                OFF_FAST_SELECT: read_word_next = {7'h00, fastSelect};
                default: read_word_next = WORD_RESET;
            endcase
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.readWordReg = read_word_next;
        if (wrSoft) begin
            next_st.softReq = pwdata[SOFT_BIT];
        end
        next_st.normalReqN = ~|normMasked;
        next_st.fastReqN = ~fastMasked[0];
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st.softReq <= SOFT_RESET;
            st.readWordReg <= WORD_RESET;
            st.normalReqN <= REQ_N_RESET;
            st.fastReqN <= REQ_N_RESET;
        end else begin
            st <= next_st;
        end
    end

    // registered outputs keep the big read mux off the bus timing path
    assign prdata = st.readWordReg;
    assign normalReqOutN = st.normalReqN;
    assign fastReqOutN = st.fastReqN;

    // ==========================================================
    // assertions
    property p_maskSet;
        @(posedge clk) disable iff (!rstN)
        wrNormSet |=> normMask == ($past(normMask) | $past(pwdata));
    endproperty
    a_maskSet: assert property (p_maskSet)
        else $error("mask set write did not or-in data");

    property p_maskClr;
        @(posedge clk) disable iff (!rstN)
        wrNormClr |=> normMask == ($past(normMask) & ~$past(pwdata));
    endproperty
    a_maskClr: assert property (p_maskClr)
        else $error("mask clear write did not clear data bits");

    property p_maskHold;
        @(posedge clk) disable iff (!rstN)
        !(wrNormSet || wrNormClr) |=> $stable(normMask);
    endproperty
    a_maskHold: assert property (p_maskHold)
        else $error("normal mask changed without set or clear write");

    property p_fastMaskHold;
        @(posedge clk) disable iff (!rstN)
        !(wrFastSet || wrFastClr) |=> $stable(fastMask);
    endproperty
    a_fastMaskHold: assert property (p_fastMaskHold)
        else $error("fast mask changed without set or clear write");

    property p_resetMask;
        @(posedge clk)
        !rstN |-> (normMask == '0) && (fastMask == '0) && normalReqOutN && fastReqOutN;
    endproperty
    a_resetMask: assert property (p_resetMask)
        else $error("masks or requests not cleared in reset");

    property p_maskedAnd;
        @(posedge clk) disable iff (!rstN)
        (normMasked == (normRaw & normMask)) && (fastMasked == (fastRaw & fastMask));
    endproperty
    a_maskedAnd: assert property (p_maskedAnd)
        else $error("masked status is not raw and mask");

    property p_normReq;
        @(posedge clk) disable iff (!rstN)
        (|normMasked) |=> !normalReqOutN;
    endproperty
    a_normReq: assert property (p_normReq)
        else $error("normal request not asserted one cycle after masked bit");

    property p_normIdle;
        @(posedge clk) disable iff (!rstN)
        (normMasked == '0) |=> normalReqOutN;
    endproperty
    a_normIdle: assert property (p_normIdle)
        else $error("normal request asserted with nothing enabled and active");

    property p_fastReq;
        @(posedge clk) disable iff (!rstN)
        ##1 fastReqOutN == !$past(fastRaw[0] & fastMask[0]);
    endproperty
    a_fastReq: assert property (p_fastReq)
        else $error("fast request is not inverse of masked fast bit");

    property p_soft;
        @(posedge clk) disable iff (!rstN)
        wrSoft |=> (st.softReq == $past(pwdata[SOFT_BIT]));
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft write did not follow data bit 1");

    property p_softRaw;
        @(posedge clk) disable iff (!rstN)
        (!normSelect && $rose(st.softReq)) |-> normRaw[SOFT_BIT];
    endproperty
    a_softRaw: assert property (p_softRaw)
        else $error("soft interrupt not visible in raw status bit 1");

    property p_testSelect;
        @(posedge clk) disable iff (!rstN)
        normSelect |-> (normRaw == normPattern);
    endproperty
    a_testSelect: assert property (p_testSelect)
        else $error("test pattern not substituted for sources");

    property p_readMask;
        @(posedge clk) disable iff (!rstN)
        (readSetup && paddr == OFF_NORMAL_MASK_SET[8:2])
            |=> prdata == $past(normMask);
    endproperty
    a_readMask: assert property (p_readMask)
        else $error("read of normal mask returned wrong data");

    property p_readUnmapped;
        @(posedge clk) disable iff (!rstN)
        (readSetup && (paddr == OFF_NORMAL_MASK_CLR[8:2] || paddr == OFF_SOFT_TRIGGER[8:2]))
            |=> prdata == WORD_RESET;
    endproperty
    a_readUnmapped: assert property (p_readUnmapped)
        else $error("write-only location did not read as zero");

    property p_noSelect;
        @(posedge clk) disable iff (!rstN)
        !blockSelect |=> prdata == WORD_RESET;
    endproperty
    a_noSelect: assert property (p_noSelect)
        else $error("read data driven without block select");

    property p_fastMaskSet;
        @(posedge clk) disable iff (!rstN)
        wrFastSet |=> fastMask == ($past(fastMask) | $past(pwdata[0]));
    endproperty
    a_fastMaskSet: assert property (p_fastMaskSet)
        else $error("fast mask set write did not or-in data bit 0");

    property p_fastMaskClr;
        @(posedge clk) disable iff (!rstN)
        wrFastClr |=> fastMask == ($past(fastMask) & ~$past(pwdata[0]));
    endproperty
    a_fastMaskClr: assert property (p_fastMaskClr)
        else $error("fast mask clear write did not clear data bit 0");

    // soft source only moves on a soft write
    property p_softHold;
        @(posedge clk) disable iff (!rstN)
        !wrSoft |=> $stable(st.softReq);
    endproperty
    a_softHold: assert property (p_softHold)
        else $error("soft interrupt changed without a soft write");

    property p_readRaw;
        @(posedge clk) disable iff (!rstN)
        (readSetup && paddr == OFF_NORMAL_RAW[8:2])
            |=> prdata == $past(normRaw);
    endproperty
    a_readRaw: assert property (p_readRaw)
        else $error("read of normal raw status returned wrong data");

    property p_readFastMask;
        @(posedge clk) disable iff (!rstN)
        (readSetup && paddr == OFF_FAST_MASK_SET[8:2])
            |=> prdata == {7'h00, $past(fastMask)};
    endproperty
    a_readFastMask: assert property (p_readFastMask)
        else $error("read of fast mask returned wrong data");

    c_softRequest: cover property (@(posedge clk) disable iff (!rstN)
        wrSoft && pwdata[SOFT_BIT] ##2 !normalReqOutN);
    c_fastRequest: cover property (@(posedge clk) disable iff (!rstN)
        $fell(fastReqOutN));
    c_testMode: cover property (@(posedge clk) disable iff (!rstN)
        normSelect && fastSelect && (normRaw != '0));
    c_rawRead: cover property (@(posedge clk) disable iff (!rstN)
        readSetup && (paddr == OFF_NORMAL_RAW[8:2]) ##1 (prdata != '0));
    c_fastTest: cover property (@(posedge clk) disable iff (!rstN)
        fastSelect && fastRaw[0]);

endmodule : afi_ctrl

// ---- tb/afi_src_model.sv ----
// Purpose: level interrupt sources standing in for the peripherals
// Assumes: each level is held until the bench asks for a new one
// Notes:   changes land on the falling edge, off the sampling edge
`timescale 1ns/1ps

module afi_src_model
    import afi_pkg::*;
(
    input wire logic clk,
    input wire logic [NORMAL_BANK_WIDTH-1:0] normalWant,
    input wire logic fastWant,
    output logic [NORMAL_BANK_WIDTH-1:0] normalSourcesIn,
    output logic fastSourceIn
);
    // ==========================================================
    // source levels
    // plain levels, never pulses: the controller has no capture of its own
    initial begin
        normalSourcesIn = '0;
        fastSourceIn = 1'b0;
    end

    always @(negedge clk) begin
        normalSourcesIn <= normalWant;
        fastSourceIn <= fastWant;
    end
endmodule : afi_src_model

// ---- tb/afi_ctrl_tb.sv ----
// Purpose: self-checking bench for the two-bank interrupt controller
// Assumes: no wait states, one idle cycle between transfers
// Notes:   fixed settle of six edges covers the source synchroniser
`timescale 1ns/1ps

module afi_ctrl_tb
    import afi_pkg::*;
;
    logic clk = 1'b0;
    // starts high so the drop below is a real edge for the async reset
    logic rstN = 1'b1;
    logic blockSelect = 1'b0;
    logic penable = 1'b0;
    logic [ADDR_WIDTH-1:0] paddr = '0;
    logic pwrite = 1'b0;
    logic [DATA_WIDTH-1:0] pwdata = '0;
    logic [DATA_WIDTH-1:0] prdata;
    logic [NORMAL_BANK_WIDTH-1:0] normalWant = '0;
    logic fastWant = 1'b0;
    logic [NORMAL_BANK_WIDTH-1:0] normalSourcesIn;
    logic fastSourceIn;
    logic normalReqOutN;
    logic fastReqOutN;
    int numErrors = 0;
    int checksDone = 0;

    always #4 clk = ~clk;

    afi_src_model u_afi_src_model (.clk(clk), .normalWant(normalWant),
        .fastWant(fastWant), .normalSourcesIn(normalSourcesIn),
        .fastSourceIn(fastSourceIn));

    afi_ctrl u_afi_ctrl (.clk(clk), .rstN(rstN), .blockSelect(blockSelect),
        .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .fastSourceIn(fastSourceIn),
        .normalSourcesIn(normalSourcesIn), .normalReqOutN(normalReqOutN),
        .fastReqOutN(fastReqOutN));

    // ==========================================================
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic sel, input logic [8:0] off, input logic isWrite,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        blockSelect = sel;
        pwrite = isWrite;
        paddr = off[8:2];
        pwdata = d;
        @(posedge clk);
        #1;
        penable = 1'b1;
        q = prdata;
        @(posedge clk);
        #1;
        blockSelect = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
    endtask : xfer

    task automatic wr(input logic [8:0] off, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, off, 1'b1, d, q);
    endtask : wr

    task automatic rdc(input logic [8:0] off, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b1, off, 1'b0, 8'h00, q);
        chk(q, exp);
    endtask : rdc

    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic reqs(input logic n, input logic f);
        chk({7'h00, normalReqOutN}, {7'h00, n});
        chk({7'h00, fastReqOutN}, {7'h00, f});
    endtask : reqs

    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [8:0] offs [13] = '{OFF_NORMAL_MASKED, OFF_NORMAL_RAW,
            OFF_NORMAL_MASK_SET, OFF_NORMAL_MASK_CLR, OFF_SOFT_TRIGGER,
            OFF_NORMAL_PATTERN, OFF_NORMAL_SELECT, OFF_FAST_MASKED, OFF_FAST_RAW,
            OFF_FAST_MASK_SET, OFF_FAST_MASK_CLR, OFF_FAST_PATTERN, OFF_FAST_SELECT};
        foreach (offs[i]) begin
            rdc(offs[i], 8'h00);
        end
        reqs(1'b1, 1'b1);
    endtask : t_reset

    task automatic t_mask();
        logic [7:0] q;
        wr(OFF_NORMAL_MASK_SET, 8'ha5);
        wr(OFF_NORMAL_MASK_SET, 8'h0a);
        rdc(OFF_NORMAL_MASK_SET, 8'haf);
        wr(OFF_NORMAL_MASK_CLR, 8'h21);
        rdc(OFF_NORMAL_MASK_SET, 8'h8e);
        wr(OFF_NORMAL_MASKED, 8'hff);
        wr(OFF_NORMAL_RAW, 8'hff);
        rdc(OFF_NORMAL_MASK_SET, 8'h8e);
        xfer(1'b0, OFF_NORMAL_MASK_SET, 1'b1, 8'hff, q);
        rdc(OFF_NORMAL_MASK_SET, 8'h8e);
        xfer(1'b0, OFF_NORMAL_MASK_SET, 1'b0, 8'h00, q);
        chk(q, 8'h00);
        rdc(OFF_NORMAL_MASK_CLR, 8'h00);
        rdc(9'h01c, 8'h00);
        rdc(9'h1fc, 8'h00);
    endtask : t_mask

    task automatic t_sources();
        normalWant = 8'hfe;
        settle();
        rdc(OFF_NORMAL_RAW, 8'hfc);
        rdc(OFF_NORMAL_MASKED, 8'h8c);
        reqs(1'b0, 1'b1);
        wr(OFF_NORMAL_MASK_CLR, 8'h8c);
        settle();
        rdc(OFF_NORMAL_MASKED, 8'h00);
        reqs(1'b1, 1'b1);
        normalWant = 8'h00;
        settle();
        rdc(OFF_NORMAL_RAW, 8'h00);
    endtask : t_sources

    task automatic t_soft();
        wr(OFF_SOFT_TRIGGER, 8'h01);
        settle();
        rdc(OFF_NORMAL_RAW, 8'h00);
        wr(OFF_SOFT_TRIGGER, 8'h02);
        settle();
        rdc(OFF_NORMAL_RAW, 8'h02);
        rdc(OFF_NORMAL_MASKED, 8'h02);
        reqs(1'b0, 1'b1);
        wr(OFF_SOFT_TRIGGER, 8'hfd);
        settle();
        rdc(OFF_NORMAL_RAW, 8'h00);
        reqs(1'b1, 1'b1);
    endtask : t_soft

    task automatic t_test();
        wr(OFF_NORMAL_PATTERN, 8'h5a);
        rdc(OFF_NORMAL_PATTERN, 8'h5a);
        wr(OFF_NORMAL_SELECT, 8'h01);
        settle();
        rdc(OFF_NORMAL_SELECT, 8'h01);
        rdc(OFF_NORMAL_RAW, 8'h5a);
        wr(OFF_NORMAL_SELECT, 8'h00);
        wr(OFF_FAST_PATTERN, 8'h01);
        wr(OFF_FAST_SELECT, 8'h01);
        settle();
        rdc(OFF_NORMAL_RAW, 8'h00);
        rdc(OFF_FAST_RAW, 8'h01);
        // fast test registers back to idle before normal traffic resumes
        wr(OFF_FAST_SELECT, 8'h00);
        wr(OFF_FAST_PATTERN, 8'h00);
    endtask : t_test

    task automatic t_fast();
        fastWant = 1'b1;
        settle();
        rdc(OFF_FAST_RAW, 8'h01);
        reqs(1'b1, 1'b1);
        wr(OFF_FAST_MASK_SET, 8'hff);
        settle();
        rdc(OFF_FAST_MASK_SET, 8'h01);
        rdc(OFF_FAST_MASKED, 8'h01);
        rdc(OFF_NORMAL_RAW, 8'h00);
        reqs(1'b1, 1'b0);
        wr(OFF_FAST_MASK_CLR, 8'h01);
        settle();
        reqs(1'b1, 1'b1);
        fastWant = 1'b0;
        // masks set, then a mid-run reset must wipe both banks
        wr(OFF_FAST_MASK_SET, 8'h01);
        wr(OFF_NORMAL_MASK_SET, 8'hff);
        rstN = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rstN = 1'b1;
        rdc(OFF_NORMAL_MASK_SET, 8'h00);
        rdc(OFF_FAST_MASK_SET, 8'h00);
        reqs(1'b1, 1'b1);
    endtask : t_fast

    // ==========================================================
    // verdict
    task automatic conclude();
        if (numErrors == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        #1;
        rstN = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rstN = 1'b1;
        t_reset();
        t_mask();
        t_sources();
        t_soft();
        t_test();
        t_fast();
        conclude();
    end
endmodule : afi_ctrl_tb
